// ### hw/cxp_pkg.sv
// Notes on behaviour
// - one exception taken per cycle, by fixed priority, reset highest.
// - master clear pin or power-on reset raises the reset exception.
// - single-step raises a debug exception after each retired instruction.
// - external debug request pin or break request bit raises debug interrupt.
// - non-maskable interrupt is raised regardless of interrupt masking.
// - interrupt raised only for an unmasked hardware or software request.
// - fetch matching an armed instruction breakpoint raises instruction break.
// - misaligned or protected fetch address raises fetch address fault.
// - bus error on fetch raises fetch bus fault.
// - debug breakpoint instruction raises debug breakpoint exception.
// - service call, break, reserved opcode each raise their own exception.
// - coprocessor instruction to disabled coprocessor raises unusable exception.
// - extension instruction while extension disabled raises extension unusable.
// - overflow-checking arithmetic with signed overflow raises overflow exception.
// - trap instruction raises trap only when its condition is true.
// - data address match, or store address plus value match, raises data break.
// - misaligned or protected load address raises load address fault.
// - misaligned or protected store address raises store address fault.
// - bus error on load or store raises data bus fault.
// - load data value breakpoint match raises load data break.
// - debug exception in run mode enters debug mode until debug return instruction or master clear.
// - wait instruction enters power-down; clocks may be slowed or halted.
package cxp_pkg;
   localparam int NUM_SRC = 22;
   localparam logic [4:0] CAUSE_NONE = 5'h1F;
   // cause codes, also the priority index (lower wins)
   localparam logic [4:0] C_RESET = 5'h00;
   localparam logic [4:0] C_DSS = 5'h01;
   localparam logic [4:0] C_DEBUG_INTERRUPT_EXCEPTION = 5'h02;
   localparam logic [4:0] C_NMI = 5'h03;
   localparam logic [4:0] C_INT = 5'h04;
   localparam logic [4:0] C_DIB = 5'h05;
   localparam logic [4:0] C_FETCH_ADDR = 5'h06;
   localparam logic [4:0] C_FETCH_BUS = 5'h07;
   localparam logic [4:0] C_DBP = 5'h08;
   localparam logic [4:0] C_SYS = 5'h09;
   localparam logic [4:0] C_BRK = 5'h0A;
   localparam logic [4:0] C_RSVD = 5'h0B;
   localparam logic [4:0] C_CPU = 5'h0C;
   localparam logic [4:0] C_EXT = 5'h0D;
   localparam logic [4:0] C_OVF = 5'h0E;
   localparam logic [4:0] C_TRAP = 5'h0F;
   localparam logic [4:0] C_DATA_BRK = 5'h10;
   localparam logic [4:0] C_LOAD_ADDR = 5'h11;
   localparam logic [4:0] C_STORE_ADDR = 5'h12;
   localparam logic [4:0] C_DATA_BUS = 5'h13;
   localparam logic [4:0] C_LOAD_DBRK = 5'h14;
   localparam logic [4:0] C_WAIT = 5'h15;
   localparam int NUM_CP = 4;
   localparam int NUM_IRQ = 8;
   typedef enum logic [1:0] {
      CXP_RUN = 2'b00,
      CXP_DEBUG = 2'b01,
      CXP_SLEEP = 2'b10
   } cxp_mode_t;
endpackage

// ### hw/cxp_prio_enc.sv
`timescale 1ns/1ns
// fixed priority pick: lowest index set wins
module cxp_prio_enc (
   input wire logic [cxp_pkg::NUM_SRC-1:0] req, // raw conditions
   output logic any, // some condition set
   output logic [4:0] idx // winning index
);
   // scan from the lowest priority up so the highest overwrites
   always_comb
   begin
      any = 1'b0;
      idx = cxp_pkg::CAUSE_NONE;
      for (int i = cxp_pkg::NUM_SRC - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            any = 1'b1;
            idx = 5'(i);
         end
      end
   end
endmodule

// ### hw/cxp_top.sv
`timescale 1ns/1ns
// exception detection and priority selection for the core
module cxp_top (
   input wire logic clk, // core clock, 100 MHz
   input wire logic rst_n, // async power-on reset, active low
   input wire logic ce, // clock enable, freezes state when low
   input wire logic master_clear_pin_n, // master clear pin, active low
   input wire logic external_debug_request_pin, // async debug request
   input wire logic nmi_pin, // async non-maskable interrupt
   input wire logic debug_break_request_bit, // from debug control reg
   input wire logic single_step_en, // single step under debug control
   input wire logic instr_retire, // an instruction retired this cycle
   input wire logic [cxp_pkg::NUM_IRQ-1:0] irq_req, // hw/sw requests
   input wire logic [cxp_pkg::NUM_IRQ-1:0] irq_mask_n, // 1 = enabled
   input wire logic irq_global_en, // global interrupt enable
   input wire logic fetch_valid, // fetch in flight
   input wire logic [31:0] fetch_addr, // fetch address
   input wire logic fetch_protected, // fetch hits protected region
   input wire logic fetch_bus_err, // bus error on fetch
   input wire logic ibrk_armed, // instruction breakpoint armed
   input wire logic [31:0] ibrk_addr, // instruction breakpoint address
   input wire logic dec_valid, // decoded instruction present
   input wire logic dec_debug_breakpoint_instruction, // debug breakpoint instruction
   input wire logic dec_service_call_instruction, // service call instruction
   input wire logic dec_break, // break instruction
   input wire logic dec_reserved, // reserved opcode
   input wire logic dec_cop, // coprocessor instruction
   input wire logic [1:0] dec_cop_num, // targeted coprocessor
   input wire logic [cxp_pkg::NUM_CP-1:0] cop_enable, // coprocessor enables
   input wire logic dec_ext, // user extension instruction
   input wire logic ext_enable, // extension enabled
   input wire logic dec_ovf_arith, // overflow-checking arithmetic
   input wire logic alu_signed_ovf, // signed overflow result
   input wire logic dec_trap, // trap instruction
   input wire logic trap_cond, // trap condition true
   input wire logic dec_wait, // wait instruction
   input wire logic dec_debug_return_instruction, // debug return instruction
   input wire logic mem_load, // load access
   input wire logic mem_store, // store access
   input wire logic [31:0] mem_addr, // data address
   input wire logic [1:0] mem_size, // 0 byte, 1 half, 2 word
   input wire logic mem_protected, // data hits protected region
   input wire logic mem_bus_err, // bus error on data access
   input wire logic [31:0] store_data, // store value
   input wire logic [31:0] load_data, // returned load value
   input wire logic load_data_valid, // load value returned
   input wire logic dbrk_armed, // data breakpoint armed
   input wire logic [31:0] dbrk_addr, // data breakpoint address
   input wire logic dbrk_val_en, // compare value as well
   input wire logic [31:0] dbrk_value, // data breakpoint value
   input wire logic wake_event, // leaves power-down
   output logic exc_req, // exception request, registered
   output logic [4:0] exc_cause, // cause code, registered
   output logic debug_mode, // in debug mode
   output logic sleep_mode, // power-down, clocks may stop
   output logic clk_gate_ok // clocks may be slowed or halted
);
   // three-stage synchronisers for pins
   logic [2:0] master_clear_pin_s_r;
   logic [2:0] dreq_s_r;
   logic [2:0] nmi_s_r;
   logic master_clear_pin_q_r;
   logic dreq_q_r;
   logic nmi_q_r;
   cxp_pkg::cxp_mode_t mode_r;
   cxp_pkg::cxp_mode_t mode_nxt;
   logic exc_req_r;
   logic [4:0] exc_cause_r;
   logic [cxp_pkg::NUM_SRC-1:0] cond;
   logic any;
   logic [4:0] idx;
   logic in_dbg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         master_clear_pin_s_r <= 3'h0;
         dreq_s_r <= 3'h0;
         nmi_s_r <= 3'h0;
      end
      else if (ce)
      begin
         master_clear_pin_s_r <= {master_clear_pin_s_r[1:0], ~master_clear_pin_n};
         dreq_s_r <= {dreq_s_r[1:0], external_debug_request_pin};
         nmi_s_r <= {nmi_s_r[1:0], nmi_pin};
      end
   end

   // a level change counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         master_clear_pin_q_r <= 1'b0;
         dreq_q_r <= 1'b0;
         nmi_q_r <= 1'b0;
      end
      else if (ce)
      begin
         if (master_clear_pin_s_r[1] == master_clear_pin_s_r[2])
            master_clear_pin_q_r <= master_clear_pin_s_r[2];
         if (dreq_s_r[1] == dreq_s_r[2])
            dreq_q_r <= dreq_s_r[2];
         if (nmi_s_r[1] == nmi_s_r[2])
            nmi_q_r <= nmi_s_r[2];
      end
   end

   assign in_dbg = (mode_r == cxp_pkg::CXP_DEBUG);

   // misalignment, breakpoint match, coprocessor and interrupt checks
   wire fetch_misal = (fetch_addr[1:0] != 2'h0);
   wire mem_misal = ((mem_size == 2'h1) && mem_addr[0])
      || ((mem_size == 2'h2) && (mem_addr[1:0] != 2'h0));
   wire ibrk_hit = ibrk_armed && (fetch_addr == ibrk_addr);
   wire dbrk_addr_hit = dbrk_armed && (mem_addr == dbrk_addr);
   wire dbrk_st_hit = dbrk_addr_hit
      && (!dbrk_val_en || (store_data == dbrk_value));
   wire cop_off = !cop_enable[dec_cop_num];
   wire irq_live = irq_global_en && |(irq_req & irq_mask_n);

   // raw condition vector, index is the cause code
   assign cond[cxp_pkg::C_RESET] = master_clear_pin_q_r;
   assign cond[cxp_pkg::C_DSS] = single_step_en && instr_retire
      && !in_dbg;
   assign cond[cxp_pkg::C_DEBUG_INTERRUPT_EXCEPTION] = (dreq_q_r || debug_break_request_bit)
      && !in_dbg;
   assign cond[cxp_pkg::C_NMI] = nmi_q_r;
   assign cond[cxp_pkg::C_INT] = irq_live && !in_dbg;
   assign cond[cxp_pkg::C_DIB] = fetch_valid && ibrk_hit
      && !in_dbg;
   assign cond[cxp_pkg::C_FETCH_ADDR] = fetch_valid
      && (fetch_misal || fetch_protected);
   assign cond[cxp_pkg::C_FETCH_BUS] = fetch_valid
      && fetch_bus_err;
   assign cond[cxp_pkg::C_DBP] = dec_valid && dec_debug_breakpoint_instruction;
   assign cond[cxp_pkg::C_SYS] = dec_valid && dec_service_call_instruction;
   assign cond[cxp_pkg::C_BRK] = dec_valid && dec_break;
   assign cond[cxp_pkg::C_RSVD] = dec_valid && dec_reserved;
   assign cond[cxp_pkg::C_CPU] = dec_valid && dec_cop && cop_off;
   assign cond[cxp_pkg::C_EXT] = dec_valid && dec_ext
      && !ext_enable;
   assign cond[cxp_pkg::C_OVF] = dec_valid && dec_ovf_arith
      && alu_signed_ovf;
   assign cond[cxp_pkg::C_TRAP] = dec_valid && dec_trap
      && trap_cond;
   assign cond[cxp_pkg::C_DATA_BRK] = !in_dbg && ((mem_load
      && dbrk_addr_hit && !dbrk_val_en)
      || (mem_store && dbrk_st_hit));
   assign cond[cxp_pkg::C_LOAD_ADDR] = mem_load
      && (mem_misal || mem_protected);
   assign cond[cxp_pkg::C_STORE_ADDR] = mem_store
      && (mem_misal || mem_protected);
   assign cond[cxp_pkg::C_DATA_BUS] = (mem_load || mem_store)
      && mem_bus_err;
   assign cond[cxp_pkg::C_LOAD_DBRK] = !in_dbg && load_data_valid
      && dbrk_armed && dbrk_val_en
      && (load_data == dbrk_value);
   assign cond[cxp_pkg::C_WAIT] = dec_valid && dec_wait
      && (mode_r == cxp_pkg::CXP_RUN);

   // highest-priority condition wins, rest discarded
   cxp_prio_enc u_prio (
      .req(cond),
      .any(any),
      .idx(idx)
   );

   wire is_debug_exc = any && ((idx == cxp_pkg::C_DSS)
      || (idx == cxp_pkg::C_DEBUG_INTERRUPT_EXCEPTION) || (idx == cxp_pkg::C_DIB)
      || (idx == cxp_pkg::C_DBP) || (idx == cxp_pkg::C_DATA_BRK)
      || (idx == cxp_pkg::C_LOAD_DBRK));
   wire is_wait = any && (idx == cxp_pkg::C_WAIT);
   wire wake = wake_event || nmi_q_r || irq_live || master_clear_pin_q_r
      || dreq_q_r;

   // mode sequencing: debug entry/exit and power-down
   always_comb
   begin
      mode_nxt = mode_r;
      case (mode_r)
         cxp_pkg::CXP_RUN:
         begin
            if (is_debug_exc)
               mode_nxt = cxp_pkg::CXP_DEBUG;
            else if (is_wait)
               mode_nxt = cxp_pkg::CXP_SLEEP;
         end
         cxp_pkg::CXP_DEBUG:
         begin
            if (dec_valid && dec_debug_return_instruction && !any)
               mode_nxt = cxp_pkg::CXP_RUN;
         end
         cxp_pkg::CXP_SLEEP:
         begin
            if (wake)
               mode_nxt = cxp_pkg::CXP_RUN;
         end
         default: mode_nxt = cxp_pkg::CXP_RUN;
      endcase
      if (master_clear_pin_q_r)
         mode_nxt = cxp_pkg::CXP_RUN;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_r <= cxp_pkg::CXP_RUN;
      else if (ce)
         mode_r <= mode_nxt;
   end

   // registered single request with cause; wait is not an exception
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         exc_req_r <= 1'b1;
         exc_cause_r <= cxp_pkg::C_RESET;
      end
      else if (ce)
      begin
         exc_req_r <= any && !is_wait;
         exc_cause_r <= (any && !is_wait) ? idx : cxp_pkg::CAUSE_NONE;
      end
   end

   assign exc_req = exc_req_r;
   assign exc_cause = exc_cause_r;
   assign debug_mode = in_dbg;
   assign sleep_mode = (mode_r == cxp_pkg::CXP_SLEEP);
   assign clk_gate_ok = (mode_r == cxp_pkg::CXP_SLEEP);
endmodule

// ### dv/cxp_props.sv
`timescale 1ns/1ns
// ties the registered exception outputs to their input conditions
module cxp_props (
   input wire logic clk, // core clock
   input wire logic rst_n, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic master_clear_pin_n, // master clear, active low
   input wire logic nmi_pin, // non-maskable request
   input wire logic [cxp_pkg::NUM_IRQ-1:0] irq_req, // requests
   input wire logic [cxp_pkg::NUM_IRQ-1:0] irq_mask_n, // enables
   input wire logic irq_global_en, // global enable
   input wire logic dec_valid, // decoded instruction
   input wire logic dec_service_call_instruction, // service call
   input wire logic dec_ovf_arith, // checked arithmetic
   input wire logic alu_signed_ovf, // signed overflow
   input wire logic dec_trap, // trap
   input wire logic trap_cond, // trap condition
   input wire logic dec_wait, // wait
   input wire logic dec_debug_return_instruction, // debug return
   input wire logic exc_req, // request
   input wire logic [4:0] exc_cause, // cause
   input wire logic debug_mode, // debug mode
   input wire logic sleep_mode, // power-down
   input wire logic clk_gate_ok // clocks may stop
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // one request, one cause, priority by code
   chk_req_code: assert property (exc_req == (exc_cause != 5'h1F))
      else $error("request and cause disagree");
   chk_reset_cause: assert property ((!master_clear_pin_n) [*7] |->
      exc_req && exc_cause == 5'h00) else $error("master clear not taken");
   chk_nmi_take: assert property (nmi_pin [*7] |->
      exc_req && exc_cause <= 5'h03) else $error("nmi not taken");
   chk_service_call_instruction_take: assert property (ce && dec_valid && dec_service_call_instruction
      |=> exc_req && exc_cause <= 5'h09) else $error("service_call_instruction lost");
   chk_ovf_take: assert property (ce && dec_valid && dec_ovf_arith
      && alu_signed_ovf |=> exc_req && exc_cause <= 5'h0E)
      else $error("overflow lost");
   chk_trap_false: assert property (ce && dec_valid && dec_trap
      && !trap_cond |=> exc_cause != 5'h0F) else $error("false trap taken");
   chk_irq_masked: assert property (ce &&
      !(irq_global_en && |(irq_req & irq_mask_n)) |=> exc_cause != 5'h04)
      else $error("masked interrupt taken");
   chk_debug_stay: assert property ((ce && master_clear_pin_n) [*7]
      ##0 (debug_mode && !dec_debug_return_instruction) |=> debug_mode)
      else $error("debug mode left early");
   chk_sleep_entry: assert property ($rose(sleep_mode) |->
      $past(dec_wait) && clk_gate_ok) else $error("bad power-down entry");
   // main scenarios reached
   cover property (debug_mode ##1 !debug_mode);
   cover property (sleep_mode);
   cover property (exc_req && exc_cause == 5'h03);
endmodule
bind cxp_top cxp_props cxp_props_i (.clk, .rst_n, .ce, .master_clear_pin_n,
   .nmi_pin, .irq_req, .irq_mask_n, .irq_global_en, .dec_valid, .dec_service_call_instruction,
   .dec_ovf_arith, .alu_signed_ovf, .dec_trap, .trap_cond, .dec_wait,
   .dec_debug_return_instruction, .exc_req, .exc_cause, .debug_mode, .sleep_mode, .clk_gate_ok);

// ### dv/cxp_pipe_model.sv
`timescale 1ns/1ns
// pipeline side: one bit of ops per decoded instruction kind
module cxp_pipe_model (
   input wire logic [31:0] ops, // bit n set issues kind n
   output logic dec_valid, // instruction present
   output logic dec_debug_breakpoint_instruction, // debug breakpoint
   output logic dec_service_call_instruction, // service call
   output logic dec_break, // break
   output logic dec_reserved, // reserved opcode
   output logic dec_cop, // coprocessor op
   output logic dec_ext, // extension op
   output logic dec_ovf_arith, // checked arithmetic
   output logic dec_trap, // trap
   output logic dec_wait, // wait
   output logic dec_debug_return_instruction // debug return
);
   // bit positions follow the cause numbering
   assign dec_valid = |ops;
   assign dec_debug_breakpoint_instruction = ops[cxp_pkg::C_DBP];
   assign dec_service_call_instruction = ops[cxp_pkg::C_SYS];
   assign dec_break = ops[cxp_pkg::C_BRK];
   assign dec_reserved = ops[cxp_pkg::C_RSVD];
   assign dec_cop = ops[cxp_pkg::C_CPU];
   assign dec_ext = ops[cxp_pkg::C_EXT];
   assign dec_ovf_arith = ops[cxp_pkg::C_OVF];
   assign dec_trap = ops[cxp_pkg::C_TRAP];
   assign dec_wait = ops[cxp_pkg::C_WAIT];
   assign dec_debug_return_instruction = ops[5'h16];
endmodule

// ### dv/cxp_top_bench.sv
`timescale 1ns/1ns
// drives the exception unit and judges cause, request and mode
module cxp_top_bench;
   logic clk = '0, rst_n = '0, ce = '1, master_clear_pin_n = '1;
   logic external_debug_request_pin = '0, nmi_pin = '0;
   logic debug_break_request_bit = '0, single_step_en = '0;
   logic instr_retire = '0, irq_global_en = '0, wake_event = '0;
   logic [7:0] irq_req = '0, irq_mask_n = '0;
   logic fetch_valid = '0, fetch_protected = '0, fetch_bus_err = '0;
   logic [31:0] fetch_addr = '0, ibrk_addr = '0, mem_addr = '0, ops = '0;
   logic [31:0] store_data = '0, dbrk_addr = '0;
   logic [31:0] load_data = 32'h5A5A_0F0F, dbrk_value = 32'h5A5A_0F0F;
   logic [1:0] dec_cop_num = 2'h2, mem_size = '0;
   logic [3:0] cop_enable = 4'hB;
   logic ext_enable = '0, alu_signed_ovf = '1, trap_cond = '1;
   logic mem_load = '0, mem_store = '0, mem_protected = '0, ibrk_armed = '0;
   logic mem_bus_err = '0, load_data_valid = '0, dbrk_armed = '0;
   logic dbrk_val_en = '0, exc_req, debug_mode, sleep_mode, clk_gate_ok;
   logic dec_valid, dec_debug_breakpoint_instruction, dec_service_call_instruction, dec_break, dec_reserved;
   logic dec_cop, dec_ext, dec_ovf_arith, dec_trap, dec_wait, dec_debug_return_instruction;
   logic [4:0] exc_cause;
   int errors = 0, check_count = 0;
   cxp_top cxp_top_i (.*);
   cxp_pipe_model cxp_pipe_model_i (.*);
   // 100 MHz clock
   initial forever #5 clk = ~clk;
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // drop every per-cycle condition
   task automatic idle();
      {single_step_en, instr_retire, irq_global_en, fetch_valid} <= '0;
      {ibrk_armed, fetch_protected, fetch_bus_err, mem_protected} <= '0;
      {mem_load, mem_store, mem_bus_err, load_data_valid, dbrk_armed} <= '0;
      {debug_break_request_bit, dbrk_val_en, wake_event} <= '0;
      {irq_req, fetch_addr, mem_addr, ops, mem_size} <= '0;
   endtask
   // conditions drop at the next edge; the answer is judged after it
   task automatic step_check(logic [4:0] exp);
      @(posedge clk);
      idle();
      #1 check("exc_cause", exp, exc_cause);
      check("exc_req", exp != 5'h1F, exc_req);
   endtask
   task automatic wait_req(logic [4:0] exp);
      repeat (10)
      begin
         @(posedge clk);
         #1;
         if (exc_req === 1'h1) break;
      end
      check("exc_cause", exp, exc_cause);
   endtask
   task automatic debug_return_instruction();
      @(posedge clk);
      ops <= 32'h0040_0000;
      @(posedge clk);
      ops <= '0;
      #1 check("debug_mode", 0, debug_mode);
   endtask
   task automatic set_cond(int k);
      case (k)
         1: {single_step_en, instr_retire} <= '1;
         2: debug_break_request_bit <= '1;
         4: {irq_req, irq_mask_n, irq_global_en} <= 17'h0_0819;
         5: {fetch_valid, ibrk_armed, fetch_addr, ibrk_addr} <=
            {2'h3, 64'h0000_1000_0000_1000};
         6: {fetch_valid, fetch_addr} <= {1'h1, 32'h0000_1002};
         7: {fetch_valid, fetch_bus_err} <= '1;
         8, 9, 10, 11: ops <= 32'h1 << k;
         16: {mem_load, dbrk_armed, mem_size, mem_addr, dbrk_addr} <=
            {4'hE, 64'h0000_2000_0000_2000};
         17: {mem_load, mem_size, mem_addr} <= 35'h5_0000_2001;
         18: {mem_store, mem_size, mem_addr} <= 35'h6_0000_2002;
         19: {mem_store, mem_bus_err} <= '1;
         20: {mem_load, load_data_valid, dbrk_armed, dbrk_val_en, mem_size,
            mem_addr} <= 38'h3E_0000_2000;
         default: ops <= 32'h1 << k;
      endcase
   endtask
   task automatic scen_causes();
      for (int k = 1; k <= 20; k++)
      begin
         if (k == 3) continue;
         @(posedge clk);
         set_cond(k);
         step_check(k[4:0]);
         if (k inside {1, 2, 5, 8, 16, 20})
         begin
            check("debug_mode", 1, debug_mode);
            debug_return_instruction();
         end
      end
   endtask
   task automatic scen_priority();
      @(posedge clk);
      {ops, fetch_valid, fetch_bus_err} <= {32'h0000_4E00, 2'h3};
      step_check(5'h07);
      @(posedge clk);
      {ops, trap_cond, irq_req, irq_global_en} <= 42'h0_0200_0007;
      step_check(5'h1F);
      @(posedge clk);
      trap_cond <= '1;
   endtask
   task automatic scen_pins();
      @(posedge clk);
      nmi_pin <= '1;
      wait_req(5'h03);
      @(posedge clk);
      {irq_req, irq_mask_n, irq_global_en} <= 17'h0_0203;
      repeat (3) @(posedge clk);
      #1 check("exc_cause", 5'h03, exc_cause);
      @(posedge clk);
      nmi_pin <= '0;
      idle();
      repeat (8) @(posedge clk);
      external_debug_request_pin <= '1;
      wait_req(5'h02);
      @(posedge clk);
      external_debug_request_pin <= '0;
      repeat (8) @(posedge clk);
      #1 check("debug_mode", 1, debug_mode);
      debug_return_instruction();
      @(posedge clk);
      master_clear_pin_n <= '0;
      wait_req(5'h00);
      repeat (3) @(posedge clk);
      #1 check("exc_cause", 5'h00, exc_cause);
      @(posedge clk);
      master_clear_pin_n <= '1;
      repeat (8) @(posedge clk);
      #1 check("exc_cause", 5'h1F, exc_cause);
   endtask
   task automatic scen_sleep();
      @(posedge clk);
      ops <= 32'h0020_0000;
      step_check(5'h1F);
      check("sleep_mode", 1, sleep_mode);
      check("clk_gate_ok", 1, clk_gate_ok);
      @(posedge clk);
      wake_event <= '1;
      @(posedge clk);
      wake_event <= '0;
      #1 check("sleep_mode", 0, sleep_mode);
   endtask
   // reset for 8 cycles, then every scenario in turn
   initial
   begin
      repeat (8) @(posedge clk);
      check("exc_cause", 5'h00, exc_cause);
      rst_n <= '1;
      scen_causes();
      scen_priority();
      scen_pins();
      scen_sleep();
      complete_run();
   end
   // cuts a hang short
   initial
   begin
      #100000;
      errors++;
      complete_run();
   end
endmodule
